// file: gpio_params.svh
// Purpose: Named constants for the four-group port block
// Assumes: Included by bare name; definitions only
// Notes: Register indices are word indices; byte address is index times four
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// Register word indices
`define GP_IDX_DATA0 16'hff00
`define GP_IDX_DATA1 16'hff01
`define GP_IDX_IN2 16'hff02
`define GP_IDX_DATA5 16'hff05
`define GP_IDX_DIR0 16'hff20
`define GP_IDX_DIR1 16'hff21
`define GP_IDX_DIR5 16'hff25
`define GP_IDX_PU0 16'hff30
`define GP_IDX_PU1 16'hff31
`define GP_IDX_PU5 16'hff35
`define GP_IDX_ALT 16'hff40

// One-hot select positions; group g adds g to the first three
`define GP_SEL_DATA 0
`define GP_SEL_DIR 3
`define GP_SEL_PU 6
`define GP_SEL_IN2 9
`define GP_SEL_ALT 10
`define GP_NSEL 11

// Implemented bits per group
`define GP_MASK_G0 8'h0f
`define GP_MASK_G1 8'hd8
`define GP_MASK_G2 8'h0f
`define GP_MASK_G5 8'h19

// Reset values
`define GP_DIR_RST 8'hff
`define GP_LATCH_RST 8'h00
`define GP_PU_RST 8'h00
`define GP_ALT_RST 3'h0

// Alternate output enable bits
`define GP_ALT_TXD 0
`define GP_ALT_TMB 1
`define GP_ALT_TMA 2

// Bus responses
`define GP_RESP_OKAY 2'h0
`define GP_RESP_SLVERR 2'h2

`endif

// file: gpio_pkg.sv
// Purpose: Types shared by the port block
// Assumes: Constants live in gpio_params.svh
// Notes: Nothing here is imported; users write gpio_pkg::name
package gpio_pkg;

	// Software view of one bidirectional group
	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] latch;
		logic [7:0] pu;
	} port_cfg_s;

	// What one group drives toward its pads
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_n;
		logic [7:0] pu;
	} pin_drive_s;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} wr_state_e;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_DATA = 2'b10
	} rd_state_e;

endpackage

// file: sync_stage.sv
// Purpose: Two-flop synchroniser for pad levels
// Assumes: Clock enable freezes both stages
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module sync_stage #(
	parameter int WIDTH = 15
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_r;

	// Both stages clear at reset so reads are defined
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= '0;
			q <= '0;
		end else if (ce) begin
			meta_r <= d;
			q <= meta_r;
		end
	end

endmodule // sync_stage

// file: four_group_gpio_ports.sv
// Purpose: Port logic for groups 0, 1, 2 and 5 behind an AXI4-Lite slave
// Assumes: Pads resolve pin level from out, oe_n and pull-up request
// Notes: One write and one read under way at a time
`timescale 1ns/1ps
`include "gpio_params.svh"
module four_group_gpio_ports #(
	parameter int ADDR_W = 18
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [3:0] group0_pins_i,
	output logic [3:0] group0_pins_o,
	output logic [3:0] group0_pins_oe_n,
	output logic [3:0] group0_pullup,
	input wire logic [3:0] group1_pins_i,
	output logic [3:0] group1_pins_o,
	output logic [3:0] group1_pins_oe_n,
	output logic [3:0] group1_pullup,
	input wire logic [3:0] group2_input_pins,
	input wire logic [2:0] group5_pins_i,
	output logic [2:0] group5_pins_o,
	output logic [2:0] group5_pins_oe_n,
	output logic [2:0] group5_pullup,
	input wire logic serial_transmit_data,
	input wire logic timer_b_output,
	input wire logic timer_a_output,
	output logic [3:0] ext_irq_inputs,
	output logic timer_output_stop_input,
	output logic converter_trigger_input,
	output logic serial_receive_data,
	output logic program_mode_select_input,
	output logic timer_b_input,
	output logic ext_irq_input_5,
	output logic timer_a_capture_input_0,
	output logic timer_a_capture_input_1
);

	////////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	// Byte address to one-hot register select; zero means unmapped or unaligned
	function automatic logic [`GP_NSEL-1:0] reg_sel(input logic [ADDR_W-1:0] a);
		logic [`GP_NSEL-1:0] s;
		s = '0;
		if (a[1:0] == 2'h0) begin
			case (a[17:2])
				`GP_IDX_DATA0: s[`GP_SEL_DATA] = 1'b1;
				`GP_IDX_DATA1: s[`GP_SEL_DATA+1] = 1'b1;
				`GP_IDX_DATA5: s[`GP_SEL_DATA+2] = 1'b1;
				`GP_IDX_DIR0: s[`GP_SEL_DIR] = 1'b1;
				`GP_IDX_DIR1: s[`GP_SEL_DIR+1] = 1'b1;
				`GP_IDX_DIR5: s[`GP_SEL_DIR+2] = 1'b1;
				`GP_IDX_PU0: s[`GP_SEL_PU] = 1'b1;
				`GP_IDX_PU1: s[`GP_SEL_PU+1] = 1'b1;
				`GP_IDX_PU5: s[`GP_SEL_PU+2] = 1'b1;
				`GP_IDX_IN2: s[`GP_SEL_IN2] = 1'b1;
				`GP_IDX_ALT: s[`GP_SEL_ALT] = 1'b1;
				default: s = '0;
			endcase
		end
		return s;
	endfunction

	// Implemented bits of bidirectional group g (0, 1, 5 in order)
	function automatic logic [7:0] grp_mask(input int g);
		case (g)
			0: return `GP_MASK_G0;
			1: return `GP_MASK_G1;
			default: return `GP_MASK_G5;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser and alternate inputs

	logic [14:0] sync_q;
	logic [7:0] pin8 [3];
	logic [7:0] in2_8;

	// Pads are registered twice before any reader sees them
	sync_stage #(.WIDTH(15)) sync_stage_i (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.d({group5_pins_i, group2_input_pins, group1_pins_i, group0_pins_i}),
		.q(sync_q)
	);

	// Spread pads onto register bit positions
	assign pin8[0] = {4'h0, sync_q[3:0]};
	assign pin8[1] = {sync_q[7], sync_q[6], 1'b0, sync_q[5], sync_q[4], 3'h0};
	assign pin8[2] = {3'h0, sync_q[14], sync_q[13], 2'h0, sync_q[12]};
	assign in2_8 = {4'h0, sync_q[11:8]};

	// Alternate inputs see the same synchronised levels as software
	assign ext_irq_inputs = sync_q[3:0];
	assign timer_output_stop_input = sync_q[0];
	assign converter_trigger_input = sync_q[3];
	assign serial_receive_data = sync_q[4];
	assign program_mode_select_input = sync_q[7];
	assign timer_b_input = sync_q[12];
	assign ext_irq_input_5 = sync_q[13];
	assign timer_a_capture_input_0 = sync_q[13];
	assign timer_a_capture_input_1 = sync_q[14];

	////////////////////////////////////////////////////////////////////////////////
	// Write channel

	gpio_pkg::wr_state_e wr_state_r;
	logic aw_held_r, w_held_r, awready_r, wready_r, bvalid_r;
	logic [1:0] bresp_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [7:0] w_data_r;
	logic w_lane0_r;
	logic aw_take, w_take, wr_go, wr_done, aw_held_nxt, w_held_nxt, wr_ok;
	logic [`GP_NSEL-1:0] wr_sel;

	// Address and data are taken independently; the write fires once both are held
	assign aw_take = awvalid && awready_r;
	assign w_take = wvalid && wready_r;
	assign wr_go = (wr_state_r == gpio_pkg::WR_IDLE) && aw_held_r && w_held_r;
	assign wr_done = (wr_state_r == gpio_pkg::WR_RESP) && bready;
	assign aw_held_nxt = !wr_done && (aw_held_r || aw_take);
	assign w_held_nxt = !wr_done && (w_held_r || w_take);
	assign wr_sel = reg_sel(aw_addr_r);
	assign wr_ok = (|wr_sel) && !wr_sel[`GP_SEL_IN2];

	// Handshake flops; ready is low while its channel is held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_r <= gpio_pkg::WR_IDLE;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `GP_RESP_OKAY;
		end else if (ce) begin
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			awready_r <= !aw_held_nxt;
			wready_r <= !w_held_nxt;
			case (wr_state_r)
				gpio_pkg::WR_IDLE: begin
					if (wr_go) begin
						wr_state_r <= gpio_pkg::WR_RESP;
						bvalid_r <= 1'b1;
						bresp_r <= wr_ok ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
					end
				end
				gpio_pkg::WR_RESP: begin
					if (bready) begin
						wr_state_r <= gpio_pkg::WR_IDLE;
						bvalid_r <= 1'b0;
					end
				end
				default: wr_state_r <= gpio_pkg::WR_IDLE;
			endcase
		end
	end

	// Payload capture; no reset needed since held flags gate use
	always_ff @(posedge aclk) begin
		if (ce && aw_take) begin
			aw_addr_r <= awaddr;
		end
		if (ce && w_take) begin
			w_data_r <= wdata[7:0];
			w_lane0_r <= wstrb[0];
		end
	end

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;

	////////////////////////////////////////////////////////////////////////////////
	// Port registers and pad drive

	gpio_pkg::port_cfg_s cfg_r [3];
	gpio_pkg::port_cfg_s cfg_nxt [3];
	gpio_pkg::pin_drive_s drv_r [3];
	gpio_pkg::pin_drive_s drv_nxt [3];
	logic [2:0] alt_r;
	logic [7:0] alt_en8 [3];
	logic [7:0] alt_val8 [3];
	logic [7:0] port_rd [3];
	logic wr_fire;

	// Only the low byte lane carries register bits
	assign wr_fire = wr_go && wr_ok && w_lane0_r;

	// Alternate outputs take the pad only when software enables them
	assign alt_en8[0] = 8'h00;
	assign alt_val8[0] = 8'h00;
	assign alt_en8[1] = {3'h0, alt_r[`GP_ALT_TXD], 4'h0};
	assign alt_val8[1] = {3'h0, serial_transmit_data, 4'h0};
	assign alt_en8[2] = {3'h0, alt_r[`GP_ALT_TMA], 3'h0, alt_r[`GP_ALT_TMB]};
	assign alt_val8[2] = {3'h0, timer_a_output, 3'h0, timer_b_output};

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_port
			// Unused direction bits stay one so they read as input mode
			assign cfg_nxt[g].dir = (wr_fire && wr_sel[`GP_SEL_DIR+g]) ?
				((w_data_r & grp_mask(g)) | ~grp_mask(g)) : cfg_r[g].dir;
			// Latch takes writes whatever the direction
			assign cfg_nxt[g].latch = (wr_fire && wr_sel[`GP_SEL_DATA+g]) ?
				(w_data_r & grp_mask(g)) : cfg_r[g].latch;
			assign cfg_nxt[g].pu = (wr_fire && wr_sel[`GP_SEL_PU+g]) ?
				(w_data_r & grp_mask(g)) : cfg_r[g].pu;
			// Input-mode bits read the pad, output-mode bits read the latch
			assign port_rd[g] = ((cfg_r[g].dir & pin8[g]) |
				(~cfg_r[g].dir & cfg_r[g].latch)) & grp_mask(g);
			assign drv_nxt[g].out = (cfg_r[g].latch & ~alt_en8[g]) | (alt_val8[g] & alt_en8[g]);
			assign drv_nxt[g].oe_n = cfg_r[g].dir | ~grp_mask(g);
			// Pull-up only on input-mode bits that are not alternate outputs
			assign drv_nxt[g].pu = cfg_r[g].pu & cfg_r[g].dir & ~alt_en8[g] &
				grp_mask(g);

			// Reset leaves every pin an undriven input with no pull-up
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					cfg_r[g] <= '{dir: `GP_DIR_RST, latch: `GP_LATCH_RST,
						pu: `GP_PU_RST};
					drv_r[g] <= '{out: 8'h00, oe_n: 8'hff, pu: 8'h00};
				end else if (ce) begin
					cfg_r[g] <= cfg_nxt[g];
					drv_r[g] <= drv_nxt[g];
				end
			end
		end
	endgenerate

	// Alternate output enables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alt_r <= `GP_ALT_RST;
		end else if (ce && wr_fire && wr_sel[`GP_SEL_ALT]) begin
			alt_r <= w_data_r[2:0];
		end
	end

	// Pads see registered drive only
	assign group0_pins_o = drv_r[0].out[3:0];
	assign group0_pins_oe_n = drv_r[0].oe_n[3:0];
	assign group0_pullup = drv_r[0].pu[3:0];
	assign group1_pins_o = {drv_r[1].out[7:6], drv_r[1].out[4:3]};
	assign group1_pins_oe_n = {drv_r[1].oe_n[7:6], drv_r[1].oe_n[4:3]};
	assign group1_pullup = {drv_r[1].pu[7:6], drv_r[1].pu[4:3]};
	assign group5_pins_o = {drv_r[2].out[4:3], drv_r[2].out[0]};
	assign group5_pins_oe_n = {drv_r[2].oe_n[4:3], drv_r[2].oe_n[0]};
	assign group5_pullup = {drv_r[2].pu[4:3], drv_r[2].pu[0]};

	////////////////////////////////////////////////////////////////////////////////
	// Read channel

	gpio_pkg::rd_state_e rd_state_r;
	logic arready_r, rvalid_r;
	logic [1:0] rresp_r;
	logic [7:0] rdata_r;
	logic [`GP_NSEL-1:0] rd_sel;
	logic [7:0] rd_val [`GP_NSEL];
	logic [7:0] rd_byte;
	logic ar_take;

	assign ar_take = arvalid && arready_r;
	assign rd_sel = reg_sel(araddr);

	// Value behind each select position
	generate
		for (g = 0; g < 3; g++) begin : g_rdv
			assign rd_val[`GP_SEL_DATA+g] = port_rd[g];
			assign rd_val[`GP_SEL_DIR+g] = cfg_r[g].dir;
			assign rd_val[`GP_SEL_PU+g] = cfg_r[g].pu;
		end
	endgenerate
	assign rd_val[`GP_SEL_IN2] = in2_8 & `GP_MASK_G2;
	assign rd_val[`GP_SEL_ALT] = {5'h00, alt_r};

	// One-hot select folds to a byte; unmapped gives zero
	always_comb begin
		rd_byte = 8'h00;
		for (int i = 0; i < `GP_NSEL; i++) begin
			rd_byte = rd_byte | (rd_sel[i] ? rd_val[i] : 8'h00);
		end
	end

	// Data is registered and rvalid raised on the same edge that takes the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_r <= gpio_pkg::RD_IDLE;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rresp_r <= `GP_RESP_OKAY;
			rdata_r <= 8'h00;
		end else if (ce) begin
			case (rd_state_r)
				gpio_pkg::RD_IDLE: begin
					arready_r <= !ar_take;
					if (ar_take) begin
						rd_state_r <= gpio_pkg::RD_DATA;
						rvalid_r <= 1'b1;
						rdata_r <= rd_byte;
						rresp_r <= (|rd_sel) ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
					end
				end
				gpio_pkg::RD_DATA: begin
					if (rready) begin
						rd_state_r <= gpio_pkg::RD_IDLE;
						rvalid_r <= 1'b0;
						arready_r <= 1'b1;
					end
				end
				default: rd_state_r <= gpio_pkg::RD_IDLE;
			endcase
		end
	end

	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rresp = rresp_r;
	assign rdata = {24'h000000, rdata_r};

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	property p_dir_reset;
		@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> (cfg_r[0].dir == `GP_DIR_RST) && (cfg_r[1].dir == `GP_DIR_RST)
			&& (cfg_r[2].dir == `GP_DIR_RST) && (&group1_pins_oe_n);
	endproperty
	a_dir_reset: assert property (p_dir_reset) else $error("Direction not input after reset");

	property p_clear_reset;
		@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> (cfg_r[0].latch == 8'h00) && (cfg_r[2].pu == 8'h00)
			&& (cfg_r[1].latch == 8'h00) && (cfg_r[1].pu == 8'h00);
	endproperty
	a_clear_reset: assert property (p_clear_reset) else $error("Latch or pull-up not clear");

	property p_dir_write;
		@(posedge aclk) disable iff (!aresetn)
		(ce && wr_fire && wr_sel[`GP_SEL_DIR]) ##1 ce |=>
			group0_pins_oe_n == $past(w_data_r[3:0], 2);
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("Group 0 drive not per direction");

	property p_latch_input;
		@(posedge aclk) disable iff (!aresetn)
		(ce && wr_fire && wr_sel[`GP_SEL_DATA+1]) |=>
			cfg_r[1].latch == ($past(w_data_r) & `GP_MASK_G1);
	endproperty
	a_latch_input: assert property (p_latch_input) else $error("Latch write lost");

	property p_no_pu_drive;
		@(posedge aclk) disable iff (!aresetn)
		((group0_pullup & ~group0_pins_oe_n) == 4'h0) &&
			((group5_pullup & ~group5_pins_oe_n) == 3'h0);
	endproperty
	a_no_pu_drive: assert property (p_no_pu_drive) else $error("Pull-up on driven pin");

	// Group 5 pull-up reference, declared ahead of the property that reads it
	logic [2:0] group5_pullup_src, g5_alt3;
	assign group5_pullup_src = {cfg_r[2].pu[4:3], cfg_r[2].pu[0]} &
		{cfg_r[2].dir[4:3], cfg_r[2].dir[0]};
	assign g5_alt3 = {alt_r[`GP_ALT_TMA], 1'b0, alt_r[`GP_ALT_TMB]};
	property p_pu_g5;
		@(posedge aclk) disable iff (!aresetn)
		ce ##1 ce |-> group5_pullup == ($past(group5_pullup_src) & ~$past(g5_alt3));
	endproperty
	a_pu_g5: assert property (p_pu_g5) else $error("Group 5 pull-up mismatch");

	property p_sync_in2;
		@(posedge aclk) disable iff (!aresetn)
		ce ##1 ce |=> sync_q[11:8] == $past(group2_input_pins, 2);
	endproperty
	a_sync_in2: assert property (p_sync_in2) else $error("Group 2 sample not two stages");

	property p_irq0;
		@(posedge aclk) disable iff (!aresetn)
		ce ##1 ce |=> ext_irq_inputs[0] == $past(group0_pins_i[0], 2);
	endproperty
	a_irq0: assert property (p_irq0) else $error("Interrupt input not from pin");

	property p_read_data0;
		@(posedge aclk) disable iff (!aresetn)
		(ce && ar_take && rd_sel[`GP_SEL_DATA]) |=>
			rvalid && rdata[7:0] == $past(port_rd[0]) && rresp == `GP_RESP_OKAY;
	endproperty
	a_read_data0: assert property (p_read_data0) else $error("Port read wrong");

	property p_in2_write;
		@(posedge aclk) disable iff (!aresetn)
		(ce && wr_go && wr_sel[`GP_SEL_IN2]) |=> bvalid && bresp == `GP_RESP_SLVERR;
	endproperty
	a_in2_write: assert property (p_in2_write) else $error("Input-only write accepted");

endmodule // four_group_gpio_ports

// file: gpio_board.sv
// Purpose: Board side of the port pins: external drivers and the pull-up loads
// Assumes: Device drive, then board drive, then pull-up decide the line level
// Notes: A line that nobody holds toggles every cycle, so stale levels never match
`timescale 1ns/1ps
module gpio_board #(
	parameter int W = 4
) (
	input wire logic aclk,
	input wire logic [W-1:0] dev_o,
	input wire logic [W-1:0] dev_oe_n,
	input wire logic [W-1:0] dev_pu,
	input wire logic [W-1:0] ext_d,
	input wire logic [W-1:0] ext_en,
	output logic [W-1:0] lvl
);
	logic [W-1:0] float_r = '0;

	////////////////////////////////////////////////////////////////////////////
	// Floating lines wander instead of keeping the last value
	always_ff @(posedge aclk) begin
		float_r <= ~float_r;
	end

	// Bench keeps its drivers off pins the device drives, so no contention model
	always_comb begin
		for (int i = 0; i < W; i++) begin
			lvl[i] = !dev_oe_n[i] ? dev_o[i] : ext_en[i] ? ext_d[i] : dev_pu[i] ? 1'b1 : float_r[i];
		end
	end
endmodule // gpio_board

// file: four_group_gpio_ports_bench.sv
// Purpose: Self-checking bench for the four-group port block over AXI4-Lite
// Assumes: One write and one read at a time; pads settle one edge after bresp
// Notes: Protection inputs are tied; clock enable and byte strobe get scenarios of their own
`timescale 1ns/1ps
`include "gpio_params.svh"
module four_group_gpio_ports_bench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [17:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = '0;
	logic stx = 1'b0, tbo = 1'b0, tao = 1'b0;
	logic ce = 1'b1;
	logic [3:0] wstrb = 4'hf;
	logic [3:0] e0_d = 4'h9, e0_en = 4'hf, e1_d = 4'h6, e1_en = 4'hf, g2 = 4'ha;
	logic [2:0] e5_d = 3'h5, e5_en = 3'h7;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [3:0] g0_i, g0_o, g0_oe, g0_pu, g1_i, g1_o, g1_oe, g1_pu, irq;
	logic [2:0] g5_i, g5_o, g5_oe, g5_pu;
	logic [7:0] alt_in;
	int err_total = 0, n_tests = 0;
	logic [15:0] idx_t [6] = '{`GP_IDX_DIR0, `GP_IDX_DIR1, `GP_IDX_DIR5,
		`GP_IDX_PU0, `GP_IDX_PU1, `GP_IDX_PU5};
	logic [7:0] rst_t [6] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};

	////////////////////////////////////////////////////////////////////////////
	four_group_gpio_ports four_group_gpio_ports_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.group0_pins_i(g0_i), .group0_pins_o(g0_o), .group0_pins_oe_n(g0_oe),
		.group0_pullup(g0_pu), .group1_pins_i(g1_i), .group1_pins_o(g1_o),
		.group1_pins_oe_n(g1_oe), .group1_pullup(g1_pu), .group2_input_pins(g2),
		.group5_pins_i(g5_i), .group5_pins_o(g5_o), .group5_pins_oe_n(g5_oe),
		.group5_pullup(g5_pu), .serial_transmit_data(stx), .timer_b_output(tbo),
		.timer_a_output(tao), .ext_irq_inputs(irq), .timer_output_stop_input(alt_in[0]),
		.converter_trigger_input(alt_in[1]), .serial_receive_data(alt_in[2]),
		.program_mode_select_input(alt_in[3]), .timer_b_input(alt_in[4]),
		.ext_irq_input_5(alt_in[5]), .timer_a_capture_input_0(alt_in[6]),
		.timer_a_capture_input_1(alt_in[7]));
	gpio_board #(.W(4)) board0_i (.aclk(aclk), .dev_o(g0_o), .dev_oe_n(g0_oe),
		.dev_pu(g0_pu), .ext_d(e0_d), .ext_en(e0_en), .lvl(g0_i));
	gpio_board #(.W(4)) board1_i (.aclk(aclk), .dev_o(g1_o), .dev_oe_n(g1_oe),
		.dev_pu(g1_pu), .ext_d(e1_d), .ext_en(e1_en), .lvl(g1_i));
	gpio_board #(.W(3)) board5_i (.aclk(aclk), .dev_o(g5_o), .dev_oe_n(g5_oe),
		.dev_pu(g5_pu), .ext_d(e5_d), .ext_en(e5_en), .lvl(g5_i));

	////////////////////////////////////////////////////////////////////////////
	// Shared checking, bus and pin tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic timeout();
		err_total++;
		$display("[FAIL] handshake expected answer seen timeout");
		results();
	endtask

	// Lets pad flops land before outputs are looked at
	task automatic settle();
		@(posedge aclk);
		#1;
	endtask

	function automatic logic [17:0] ad(input logic [15:0] i);
		return {i, 2'b00};
	endfunction

	// Address and data offered together; each dropped at its own handshake
	task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] er);
		bit aw, w;
		int n;
		aw = 0;
		w = 0;
		n = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w = 1;
				wvalid <= 1'b0;
			end
			if (++n > 50) timeout();
		end
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (++n > 50) timeout();
		end while (!bvalid);
		bready <= 1'b0;
		check("bresp", bresp, er);
	endtask

	task automatic rd(input logic [17:0] a, input logic [7:0] e, input logic [1:0] er);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (++n > 50) timeout();
		end while (!arready);
		arvalid <= 1'b0;
		// Raised only after the address is taken so back-to-back reads never
		// touch rready twice in one time step
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (++n > 50) timeout();
		end while (!rvalid);
		rready <= 1'b0;
		check("rdata", rdata, {24'h0, e});
		check("rresp", rresp, er);
	endtask

	// Board pins change; alternate inputs must lag by exactly two edges
	task automatic drive_pins(input logic [3:0] p0, input logic [3:0] p1, input logic [2:0] p5);
		logic [7:0] old;
		old = alt_in;
		e0_d <= p0;
		e1_d <= p1;
		e5_d <= p5;
		settle();
		check("alt_in_early", alt_in, old);
		settle();
		check("alt_in", alt_in, {p5[2], p5[1], p5[1], p5[0], p1[3], p1[0], p0[3], p0[0]});
		check("ext_irq", irq, p0);
	endtask

	task automatic reset_chk();
		check("g0_oe_n", g0_oe, 4'hf);
		check("g1_oe_n", g1_oe, 4'hf);
		check("g5_oe_n", g5_oe, 3'h7);
		check("pads_out", {g0_o, g1_o, g5_o}, '0);
		check("pullups", {g0_pu, g1_pu, g5_pu}, '0);
		for (int i = 0; i < 6; i++) begin
			rd(ad(idx_t[i]), rst_t[i], `GP_RESP_OKAY);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #5 aclk = ~aclk;
	end

	// Main sequence
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) settle();
		reset_chk();
		// Clock enable low freezes the synchroniser
		ce <= 1'b0;
		e0_d <= 4'h6;
		repeat (3) settle();
		check("irq_frozen", irq, 4'h9);
		ce <= 1'b1;
		repeat (2) settle();
		check("irq_ce", irq, 4'h6);
		drive_pins(4'h6, 4'h9, 3'h2);
		rd(ad(`GP_IDX_DATA0), 8'h06, `GP_RESP_OKAY);
		rd(ad(`GP_IDX_DATA1), 8'h88, `GP_RESP_OKAY);
		rd(ad(`GP_IDX_DATA5), 8'h08, `GP_RESP_OKAY);
		rd(ad(`GP_IDX_IN2), 8'h0a, `GP_RESP_OKAY);
		// Latch written while the pin is still an input
		wr(ad(`GP_IDX_DATA0), 8'h05, `GP_RESP_OKAY);
		rd(ad(`GP_IDX_DATA0), 8'h06, `GP_RESP_OKAY);
		e0_en <= 4'h0;
		wr(ad(`GP_IDX_DIR0), 8'hf0, `GP_RESP_OKAY);
		settle();
		check("g0_oe_n", g0_oe, 4'h0);
		check("g0_o", g0_o, 4'h5);
		rd(ad(`GP_IDX_DATA0), 8'h05, `GP_RESP_OKAY);
		wr(ad(`GP_IDX_PU0), 8'h0f, `GP_RESP_OKAY);
		settle();
		check("g0_pu", g0_pu, 4'h0);
		wr(ad(`GP_IDX_DIR0), 8'hf3, `GP_RESP_OKAY);
		repeat (3) settle();
		check("g0_pu", g0_pu, 4'h3);
		rd(ad(`GP_IDX_DATA0), 8'h07, `GP_RESP_OKAY);
		// Group 1 bit mapping and pull-ups
		e1_en <= 4'h0;
		wr(ad(`GP_IDX_PU1), 8'hd8, `GP_RESP_OKAY);
		settle();
		check("g1_pu", g1_pu, 4'hf);
		wr(ad(`GP_IDX_DATA1), 8'h90, `GP_RESP_OKAY);
		wr(ad(`GP_IDX_DIR1), 8'h27, `GP_RESP_OKAY);
		settle();
		check("g1_oe_n", g1_oe, 4'h0);
		check("g1_o", g1_o, 4'ha);
		check("g1_pu", g1_pu, 4'h0);
		rd(ad(`GP_IDX_DIR1), 8'h27, `GP_RESP_OKAY);
		// Group 5 bit mapping and pull-ups
		e5_en <= 3'h0;
		wr(ad(`GP_IDX_PU5), 8'h19, `GP_RESP_OKAY);
		settle();
		check("g5_pu", g5_pu, 3'h7);
		wr(ad(`GP_IDX_DATA5), 8'h11, `GP_RESP_OKAY);
		wr(ad(`GP_IDX_DIR5), 8'he6, `GP_RESP_OKAY);
		settle();
		check("g5_o", g5_o, 3'h5);
		check("g5_oe_n", g5_oe, 3'h0);
		check("g5_pu", g5_pu, 3'h0);
		rd(ad(`GP_IDX_DATA5), 8'h11, `GP_RESP_OKAY);
		// Alternate outputs replace the latch and block pull-ups
		tao <= 1'b1;
		wr(ad(`GP_IDX_ALT), 8'h07, `GP_RESP_OKAY);
		settle();
		check("g1_o", g1_o, 4'h8);
		check("g5_o", g5_o, 3'h4);
		stx <= 1'b1;
		settle();
		check("g1_o_alt", g1_o, 4'ha);
		wr(ad(`GP_IDX_DIR1), 8'hff, `GP_RESP_OKAY);
		settle();
		check("g1_pu", g1_pu, 4'hd);
		// Refused accesses leave state alone
		wr(ad(`GP_IDX_IN2), 8'h0f, `GP_RESP_SLVERR);
		wr(ad(`GP_IDX_DATA0) | 18'h1, 8'h00, `GP_RESP_SLVERR);
		rd(ad(16'hff10), 8'h00, `GP_RESP_SLVERR);
		// Low byte lane off: write answers but the latch keeps its value
		wstrb <= 4'he;
		wr(ad(`GP_IDX_DATA0), 8'h00, `GP_RESP_OKAY);
		wstrb <= 4'hf;
		rd(ad(`GP_IDX_DATA0), 8'h07, `GP_RESP_OKAY);
		// Second reset in mid-run
		aresetn <= 1'b0;
		repeat (2) settle();
		aresetn <= 1'b1;
		repeat (3) settle();
		reset_chk();
		wr(ad(`GP_IDX_DIR0), 8'hf0, `GP_RESP_OKAY);
		settle();
		check("g0_o", g0_o, 4'h0);
		results();
	end
endmodule // four_group_gpio_ports_bench
